/* File: smsc_cfg.svh */
// address map, field positions, reset values and divider counts of the serial controller
`ifndef SMSC_CFG_SVH
`define SMSC_CFG_SVH

// byte addresses of the three registers on the wishbone slave
`define SMSC_OFS_CONTROL 4'h0
`define SMSC_OFS_STATUS 4'h4
`define SMSC_OFS_DATA 4'h8

// reset values
`define SMSC_CTRL_RESET 8'h00
`define SMSC_BYTE_ZERO 8'h00
`define SMSC_WORD_ZERO 32'h0000_0000
`define SMSC_RESERVED_ZERO 5'h00

// status field positions
`define SMSC_STAT_DONE_BIT 7
`define SMSC_STAT_COLL_BIT 6
`define SMSC_STAT_DOUBLE_BIT 0

// half sck periods in clk cycles, normal speed
`define SMSC_HALF_DIV4 7'h02
`define SMSC_HALF_DIV16 7'h08
`define SMSC_HALF_DIV64 7'h20
`define SMSC_HALF_DIV128 7'h40
// half sck periods in clk cycles, double speed
`define SMSC_HALF_DIV2 7'h01
`define SMSC_HALF_DIV8 7'h04
`define SMSC_HALF_DIV32 7'h10
`define SMSC_HALF_DIV64X 7'h20

// byte framing: eight samples, sixteen master half periods
`define SMSC_LAST_BIT 3'h7
`define SMSC_FIRST_BIT 3'h0
`define SMSC_LAST_EDGE 4'hf
`define SMSC_FIRST_EDGE 4'h0
`define SMSC_CNT_ONE 7'h01

`endif

/* File: smsc_pkg.sv */
// shared types of the serial controller
package smsc_pkg;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic irqEnableBit;
        logic portEnableBit;
        logic bitOrderSelect;
        logic roleSelectBit;
        logic clockIdleLevel;
        logic clockSamplePhase;
        logic rateSelectHi;
        logic rateSelectLo;
    } smsc_ctrl_s;

    // status register layout, bit 7 down to bit 0
    typedef struct packed {
        logic transferDoneFlag;
        logic writeCollisionFlag;
        logic [4:0] reserved;
        logic doubleRateBit;
    } smsc_stat_s;

    // master clock generator state
    typedef enum logic {
        MST_IDLE,
        MST_RUN
    } smsc_mst_e;

endpackage : smsc_pkg

/* File: smsc_rate_div.sv */
// sck rate divider: one-cycle pulse every half sck period while running
`timescale 1ns/1ps
`include "smsc_cfg.svh"

module smsc_rate_div #(
    parameter int CNT_W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic run,
    input wire logic [2:0] rateCode,
    // half period pulse
    output logic halfTick
);

    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] cnt_r;
    logic tick_r;
    wire wrap = (cnt_r == half - `SMSC_CNT_ONE);

    // rate code is {double, hi, lo}
    always_comb
    begin
        unique case (rateCode)
            3'h0: half = `SMSC_HALF_DIV4;
            3'h1: half = `SMSC_HALF_DIV16;
            3'h2: half = `SMSC_HALF_DIV64;
            3'h3: half = `SMSC_HALF_DIV128;
            3'h4: half = `SMSC_HALF_DIV2;
            3'h5: half = `SMSC_HALF_DIV8;
            3'h6: half = `SMSC_HALF_DIV32;
            3'h7: half = `SMSC_HALF_DIV64X;
        endcase
    end

    // counter restarts whenever the generator is stopped
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= (!run || wrap) ? '0 : cnt_r + `SMSC_CNT_ONE;
            tick_r <= run && wrap;
        end
    end

    assign halfTick = tick_r;

endmodule : smsc_rate_div

/* File: smsc_pin_sampler.sv */
// registers input pins on clk and flags their edges
`timescale 1ns/1ps

module smsc_pin_sampler #(
    parameter int W = 2,
    parameter logic [W-1:0] RESET_VAL = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // raw pins
    input wire logic [W-1:0] pinIn,
    // sampled level and edge pulses
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] cur_r;
    logic [W-1:0] old_r;

    // one sampling stage and one history stage per pin
    for (genvar i = 0; i < W; i++)
    begin : g_pin
        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                cur_r[i] <= RESET_VAL[i];
                old_r[i] <= RESET_VAL[i];
            end
            else
            begin
                cur_r[i] <= pinIn[i];
                old_r[i] <= cur_r[i];
            end
        end
        assign rise[i] = cur_r[i] & ~old_r[i];
        assign fall[i] = ~cur_r[i] & old_r[i];
    end

    assign level = cur_r;

endmodule : smsc_pin_sampler

/* File: smsc_controller.sv */
// byte-wide spi master/slave controller with wishbone register access
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "smsc_cfg.svh"

// Summary of operation
// - slave: select is input; while low active, miso driven only if configured output
// - slave select high: passive, bit counter and partial byte dropped at once
// - master with select as output: select pin ignored by the controller
// - master with select input low: become slave, set done flag
// - interrupt requested when enable bit, done flag and global enable all set
// - nothing serial happens unless the enable bit is one
// - bit order bit one sends lsb first, zero sends msb first
// - role bit one master, zero slave; software re-sets it after a fault
// - polarity bit picks sck idle level and direction of leading edge
// - phase bit zero samples on leading edge, one samples on trailing edge
// - rate bits and double bit pick master divider; no effect in slave
// - done flag set at byte end; cleared by vector or status read then data access
// - collision flag set on data write mid-transfer; cleared by status read then data access, not by vector
// - status bits five to one always read zero
// - status bit zero doubles master rate and is its only writable bit
// - data write loads shifter and starts; data read returns receive buffer
// - master: write starts clock, eight bits shift, clock stops, flag set
// - single buffered transmit, double buffered receive, overrun overwrites
// - slave sck is sampled on clk, never used as a clock
module smsc_controller (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // processor side
    input wire logic globalIrqEnable,
    input wire logic irqVectorAck,
    output logic irq,
    // pin direction choices made by software in the port logic
    input wire logic ssDirOut,
    input wire logic sckDirOut,
    input wire logic mosiDirOut,
    input wire logic misoDirOut,
    // serial pins
    input wire logic ssIn,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe_n,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe_n,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    smsc_pkg::smsc_ctrl_s ctrl_r;
    logic doubleRateBit_r;
    logic transferDoneFlag_r;
    logic writeCollisionFlag_r;
    logic statusArmed_r;
    smsc_pkg::smsc_mst_e mst_r;
    logic [3:0] edgeCnt_r;
    logic [2:0] bitCnt_r;
    logic [7:0] shift_r;
    logic [7:0] rxBuf_r;
    logic txBit_r;
    logic sckLevel_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic irq_r;
    logic sckOe_n_r;
    logic mosiOe_n_r;
    logic misoOe_n_r;

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    // request is answered one cycle later; effects land on the ack edge
    wire busReq = cyc_i & stb_i;
    wire commit = busReq & ack_r;
    wire hitCtrl = (adr_i == `SMSC_OFS_CONTROL);
    wire hitStat = (adr_i == `SMSC_OFS_STATUS);
    wire hitData = (adr_i == `SMSC_OFS_DATA);
    wire wrCtrl = commit & we_i & sel_i[0] & hitCtrl;
    wire wrStat = commit & we_i & sel_i[0] & hitStat;
    wire wrData = commit & we_i & sel_i[0] & hitData;
    wire rdStat = commit & ~we_i & hitStat;
    wire dataAccess = wrData | (commit & ~we_i & hitData);

    ////////////////////////////////////////////////////////////////////////////////
    // pin sampling and rate divider

    logic [1:0] pinLvl;
    logic [1:0] pinRise;
    logic [1:0] pinFall;
    logic halfTick;

    smsc_pin_sampler #(
        .W(2),
        .RESET_VAL(2'h2)
    ) u_sampler (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn({ssIn, sckIn}),
        .level(pinLvl),
        .rise(pinRise),
        .fall(pinFall)
    );

    smsc_rate_div #(
        .CNT_W(7)
    ) u_div (
        .clk(clk),
        .reset_n(reset_n),
        .run(mst_r == smsc_pkg::MST_RUN),
        .rateCode({doubleRateBit_r, ctrl_r.rateSelectHi, ctrl_r.rateSelectLo}),
        .halfTick(halfTick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // mode decode

    wire enable = ctrl_r.portEnableBit;
    wire isMaster = enable & ctrl_r.roleSelectBit;
    wire isSlave = enable & ~ctrl_r.roleSelectBit;
    wire ssLow = ~pinLvl[1];
    // select only matters to a master when it is an input
    wire modeFault = isMaster & ~ssDirOut & ssLow;
    wire slvActive = isSlave & ssLow;
    wire slvReset = ~ctrl_r.roleSelectBit & ~ssLow;
    wire mstRun = (mst_r == smsc_pkg::MST_RUN);

    ////////////////////////////////////////////////////////////////////////////////
    // edge events

    // master: even half period ends on a leading edge, odd on a trailing one
    wire mstLead = mstRun & halfTick & ~edgeCnt_r[0];
    wire mstTrail = mstRun & halfTick & edgeCnt_r[0];
    wire mstLast = mstRun & halfTick & (edgeCnt_r == `SMSC_LAST_EDGE);
    // slave: leading edge leaves the idle level
    wire slvLead = slvActive & (ctrl_r.clockIdleLevel ? pinFall[0] : pinRise[0]);
    wire slvTrail = slvActive & (ctrl_r.clockIdleLevel ? pinRise[0] : pinFall[0]);
    wire leadEv = ctrl_r.roleSelectBit ? mstLead : slvLead;
    wire trailEv = ctrl_r.roleSelectBit ? mstTrail : slvTrail;
    wire sampleEv = ctrl_r.clockSamplePhase ? trailEv : leadEv;
    wire setupEv = ctrl_r.clockSamplePhase ? leadEv : trailEv;
    wire lastSample = sampleEv & (bitCnt_r == `SMSC_LAST_BIT);

    ////////////////////////////////////////////////////////////////////////////////
    // data path decode

    wire inBit = ctrl_r.roleSelectBit ? misoIn : mosiIn;
    wire lsbFirst = ctrl_r.bitOrderSelect;
    wire outBit = lsbFirst ? shift_r[0] : shift_r[7];
    wire firstOfLoad = lsbFirst ? dat_i[0] : dat_i[7];
    wire [7:0] shiftNxt = lsbFirst ? {inBit, shift_r[7:1]} : {shift_r[6:0], inBit};
    wire xferBusy = mstRun | (slvActive & (bitCnt_r != `SMSC_FIRST_BIT));
    wire loadEv = wrData & ~xferBusy;
    wire collEv = wrData & xferBusy & enable;
    wire startEv = loadEv & isMaster & ~modeFault;
    wire doneEv = (ctrl_r.roleSelectBit ? mstLast : lastSample) | modeFault;
    wire anyFlag = transferDoneFlag_r | writeCollisionFlag_r;
    wire clearFlags = dataAccess & statusArmed_r;

    // read mux; reserved status bits forced to zero
    smsc_pkg::smsc_stat_s statView;
    assign statView.transferDoneFlag = transferDoneFlag_r;
    assign statView.writeCollisionFlag = writeCollisionFlag_r;
    assign statView.reserved = `SMSC_RESERVED_ZERO;
    assign statView.doubleRateBit = doubleRateBit_r;
    wire [7:0] rdByte = hitCtrl ? ctrl_r :
                        hitStat ? statView :
                        hitData ? rxBuf_r : `SMSC_BYTE_ZERO;

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone answer

    // ack pulses for one cycle; unmapped reads return zero
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_r <= 1'b0;
            dat_r <= `SMSC_WORD_ZERO;
        end
        else
        begin
            ack_r <= busReq & ~ack_r;
            dat_r <= (busReq & ~ack_r & ~we_i) ? {24'h000000, rdByte} : `SMSC_WORD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control and status registers

    // a fault clears the role bit even against a same-cycle write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_r <= `SMSC_CTRL_RESET;
            doubleRateBit_r <= 1'b0;
        end
        else
        begin
            if (wrCtrl)
                ctrl_r <= dat_i[7:0];
            if (modeFault)
                ctrl_r.roleSelectBit <= 1'b0;
            if (wrStat)
                doubleRateBit_r <= dat_i[`SMSC_STAT_DOUBLE_BIT];
        end
    end

    // flags: a set in the clearing cycle wins
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            transferDoneFlag_r <= 1'b0;
            writeCollisionFlag_r <= 1'b0;
            statusArmed_r <= 1'b0;
        end
        else
        begin
            transferDoneFlag_r <= doneEv | (transferDoneFlag_r & ~clearFlags & ~irqVectorAck);
            writeCollisionFlag_r <= collEv | (writeCollisionFlag_r & ~clearFlags);
            statusArmed_r <= (rdStat & anyFlag) | (statusArmed_r & ~dataAccess);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // master clock generator

    // sixteen half periods make eight sck pulses, then the generator stops
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mst_r <= smsc_pkg::MST_IDLE;
            edgeCnt_r <= `SMSC_FIRST_EDGE;
        end
        else
        begin
            unique case (mst_r)
                smsc_pkg::MST_IDLE:
                begin
                    edgeCnt_r <= `SMSC_FIRST_EDGE;
                    if (startEv)
                        mst_r <= smsc_pkg::MST_RUN;
                end
                smsc_pkg::MST_RUN:
                begin
                    if (halfTick)
                        edgeCnt_r <= edgeCnt_r + 4'h1;
                    if (mstLast | modeFault | ~isMaster)
                        mst_r <= smsc_pkg::MST_IDLE;
                end
            endcase
        end
    end

    // sck idles at the polarity level and toggles each half period
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sckLevel_r <= 1'b0;
        else if (mstRun & halfTick & ~mstLast)
            sckLevel_r <= ~sckLevel_r;
        else if (~mstRun | mstLast)
            sckLevel_r <= ctrl_r.clockIdleLevel;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shifter and receive buffer

    // bit counter restarts on every master load and, with the role bit zero, while select is high
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            bitCnt_r <= `SMSC_FIRST_BIT;
        else if (slvReset | startEv)
            bitCnt_r <= `SMSC_FIRST_BIT;
        else if (sampleEv)
            bitCnt_r <= bitCnt_r + 3'h1;
    end

    // one shifter for both roles; receive buffer holds the last full byte
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift_r <= `SMSC_BYTE_ZERO;
            rxBuf_r <= `SMSC_BYTE_ZERO;
        end
        else
        begin
            if (loadEv)
                shift_r <= dat_i[7:0];
            else if (sampleEv)
                shift_r <= shiftNxt;
            if (lastSample)
                rxBuf_r <= shiftNxt;
        end
    end

    // output bit: first bit at load for phase zero, else at each setup edge
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            txBit_r <= 1'b0;
        else if (loadEv & ~ctrl_r.clockSamplePhase)
            txBit_r <= firstOfLoad;
        else if (setupEv | (slvReset & ~ctrl_r.clockSamplePhase))
            txBit_r <= outBit;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin drive and interrupt

    // drivers enabled only in the role and direction software chose
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sckOe_n_r <= 1'b1;
            mosiOe_n_r <= 1'b1;
            misoOe_n_r <= 1'b1;
            irq_r <= 1'b0;
        end
        else
        begin
            sckOe_n_r <= ~(isMaster & ~modeFault & sckDirOut);
            mosiOe_n_r <= ~(isMaster & ~modeFault & mosiDirOut);
            misoOe_n_r <= ~(slvActive & misoDirOut);
            irq_r <= ctrl_r.irqEnableBit & transferDoneFlag_r & globalIrqEnable;
        end
    end

    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign irq = irq_r;
    assign sckOut = sckLevel_r;
    assign sckOe_n = sckOe_n_r;
    assign mosiOut = txBit_r;
    assign mosiOe_n = mosiOe_n_r;
    assign misoOut = txBit_r;
    assign misoOe_n = misoOe_n_r;

endmodule : smsc_controller

/* File: smsc_controller_checker.sv */
// port assertions for the serial controller
`timescale 1ns/1ps
`include "smsc_cfg.svh"

module smsc_controller_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // processor side
    input wire logic globalIrqEnable,
    input wire logic irqVectorAck,
    input wire logic irq,
    // pins
    input wire logic ssDirOut,
    input wire logic misoDirOut,
    input wire logic ssIn,
    input wire logic sckOe_n,
    input wire logic mosiOe_n,
    input wire logic misoOe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////
    // bus answers after one wait cycle, for one cycle
    ack_wait_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered in time");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    status_zero_a: assert property (ack_o && !we_i && adr_i == `SMSC_OFS_STATUS
        |-> dat_o[5:1] == `SMSC_RESERVED_ZERO && dat_o[31:8] == 24'h000000)
        else $error("reserved status bits not zero");

    ////////////////////////////////////////////////////////////////////////////
    // pin directions
    miso_cfg_a: assert property (!misoOe_n |-> misoDirOut)
        else $error("miso driven without output choice");
    master_miso_a: assert property (!sckOe_n |-> misoOe_n)
        else $error("miso driven while sck driven");
    slave_idle_a: assert property (ssIn [*4] |-> misoOe_n)
        else $error("miso driven while deselected");
    fault_release_a: assert property ((!ssDirOut && !ssIn) [*5] |-> sckOe_n && mosiOe_n)
        else $error("sck or mosi driven while selected as slave");

    ////////////////////////////////////////////////////////////////////////////
    // interrupt request
    irq_gate_a: assert property (!globalIrqEnable |=> !irq)
        else $error("irq without global enable");
    vector_clear_a: assert property (irqVectorAck |-> ##2 !irq)
        else $error("irq not cleared by vector");

    // main scenarios reached
    cover property ($rose(irq));
    cover property (!misoOe_n);
    cover property (!ssDirOut && !ssIn ##5 sckOe_n);
endmodule : smsc_controller_checker

bind smsc_controller smsc_controller_checker chk (.clk, .reset_n, .cyc_i, .stb_i, .we_i,
    .adr_i, .dat_o, .ack_o, .globalIrqEnable, .irqVectorAck, .irq, .ssDirOut,
    .misoDirOut, .ssIn, .sckOe_n, .mosiOe_n, .misoOe_n);

/* File: smsc_far_slave.sv */
// behavioural spi slave on the far side of the serial pins
`timescale 1ns/1ps

module smsc_far_slave (
    // serial pins
    input wire logic sck,
    input wire logic selN,
    input wire logic mosi,
    output logic miso,
    // frame format
    input wire logic clock_idle_level,
    input wire logic clock_sample_phase,
    input wire logic lsbFirst,
    // byte data
    input wire logic [7:0] txByte,
    output logic [7:0] rxByte
);
    int cnt = 0;

    // bit k of the byte in the chosen order
    function automatic logic pick(input int k);
        pick = lsbFirst ? txByte[k[2:0]] : txByte[3'h7 - k[2:0]];
    endfunction : pick

    // idle level
    initial miso = 1'b0;

    // phase zero puts the first bit out before any edge
    always @(negedge selN)
    begin
        cnt = 0;
        miso = clock_sample_phase ? miso : pick(0);
    end

    // a released line shows the inverse of its last bit
    always @(posedge selN)
        miso = ~miso;

    // sample on one edge, set up on the other
    always @(sck)
    begin
        if (!selN && ((sck != clock_idle_level) != clock_sample_phase))
            rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
        else if (!selN)
        begin
            miso = pick(cnt + (clock_sample_phase ? 0 : 1));
            cnt++;
        end
    end
endmodule : smsc_far_slave

/* File: smsc_controller_test.sv */
// self-checking bench for the serial controller
`timescale 1ns/1ps
`include "smsc_cfg.svh"

module smsc_controller_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, gie = 1'b0, vecAck = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, irq, sckOut, sckOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n, misoFar;
    logic ssDir = 1'b1, selN = 1'b1, sckDrv = 1'b0, mosiDrv = 1'b0, sckPrev = 1'b0, oeSeen;
    logic [7:0] farTx = 8'h00, farRx, q = 8'h00, mGot;
    logic [7:0] div [8] = '{8'h04, 8'h10, 8'h40, 8'h80, 8'h02, 8'h08, 8'h20, 8'h40};
    smsc_pkg::smsc_ctrl_s cfg = '0;
    int fail_count = 0, n_checks = 0, edges = 0, run = 0, halfLen = 0;
    wire sckW = sckOe_n ? sckDrv : sckOut;
    wire mosiW = mosiOe_n ? mosiDrv : mosiOut;
    wire misoW = misoOe_n ? misoFar : misoOut;

    // clock
    initial
        forever #12.5 clk = ~clk;

    smsc_controller uut (.clk(clk), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .globalIrqEnable(gie), .irqVectorAck(vecAck), .irq(irq), .ssDirOut(ssDir),
        .sckDirOut(1'b1), .mosiDirOut(1'b1), .misoDirOut(1'b1), .ssIn(selN), .sckIn(sckW),
        .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiIn(mosiW), .mosiOut(mosiOut),
        .mosiOe_n(mosiOe_n), .misoIn(misoW), .misoOut(misoOut), .misoOe_n(misoOe_n));

    smsc_far_slave far (.sck(sckW), .selN(selN), .mosi(mosiW), .miso(misoFar),
        .clock_idle_level(cfg.clockIdleLevel), .clock_sample_phase(cfg.clockSamplePhase),
        .lsbFirst(cfg.bitOrderSelect), .txByte(farTx), .rxByte(farRx));

    // sck toggle count and last half period
    always @(posedge clk)
    begin
        halfLen = (sckOut !== sckPrev) ? run + 1 : halfLen;
        run = (sckOut !== sckPrev) ? 0 : run + 1;
        edges = edges + ((sckOut !== sckPrev) ? 1 : 0);
        sckPrev = sckOut;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic hang(input string nm);
        check(nm, 8'h01, 8'h00);
        report_and_stop();
    endtask : hang

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // one classic wishbone cycle; read data lands in q
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        for (int i = 0; i < 20 && ack !== 1'b1; i++) @(negedge clk);
        if (ack !== 1'b1) hang("ack");
        q = rdat[7:0];
        @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus

    // read a register and compare its byte
    task automatic rdc(input logic [3:0] a, input string nm, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(nm, e, q);
    endtask : rdc

    task automatic start(input logic [7:0] d);
        selN <= 1'b0;
        repeat (3) @(posedge clk);
        edges = 0;
        bus(1'b1, `SMSC_OFS_DATA, d);
    endtask : start

    task automatic wait_done();
        q = 8'h00;
        for (int i = 0; i < 600 && q[7] !== 1'b1; i++) bus(1'b0, `SMSC_OFS_STATUS, 8'h00);
        if (q[7] !== 1'b1) hang("done");
        selN <= 1'b1;
    endtask : wait_done

    // external master, mode 0 msb first, sck at clk over eight
    task automatic slv(input logic [7:0] b, input int n);
        selN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            mosiDrv <= b[7 - i];
            repeat (4) @(posedge clk);
            mGot[7 - i] = misoW;
            sckDrv <= 1'b1;
            repeat (4) @(posedge clk);
            sckDrv <= 1'b0;
        end
        oeSeen = misoOe_n;
        repeat (4) @(posedge clk);
        selN <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : slv

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdc(`SMSC_OFS_CONTROL, "control", 8'h00);
        rdc(4'hc, "unmapped", 8'h00);
        bus(1'b1, `SMSC_OFS_STATUS, 8'hff);
        rdc(`SMSC_OFS_STATUS, "status", 8'h01);
        // every mode, order and rate code
        for (int k = 0; k < 8; k++)
        begin
            cfg = smsc_pkg::smsc_ctrl_s'({2'b01, k[0], 1'b1, k[1], k[2], k[1], k[0]});
            bus(1'b1, `SMSC_OFS_CONTROL, cfg);
            bus(1'b1, `SMSC_OFS_STATUS, {7'h00, k[2]});
            farTx = 8'h93 ^ k[7:0];
            start(8'h2c + k[7:0]);
            wait_done();
            check("done", {7'h40, k[2]}, q);
            check("sck period", div[k], 8'(halfLen * 2));
            check("sck edges", 8'h10, edges[7:0]);
            check("far rx", 8'h2c + k[7:0], farRx);
            rdc(`SMSC_OFS_DATA, "rx buffer", farTx);
            rdc(`SMSC_OFS_STATUS, "cleared", {7'h00, k[2]});
            rdc(`SMSC_OFS_CONTROL, "role kept", cfg);
        end
        // write collision mid-transfer
        cfg = smsc_pkg::smsc_ctrl_s'(8'h50);
        bus(1'b1, `SMSC_OFS_CONTROL, cfg);
        bus(1'b1, `SMSC_OFS_STATUS, 8'h00);
        start(8'h11);
        bus(1'b1, `SMSC_OFS_DATA, 8'h77);
        wait_done();
        check("collision", 8'hc0, q);
        check("far rx", 8'h11, farRx);
        bus(1'b0, `SMSC_OFS_DATA, 8'h00);
        rdc(`SMSC_OFS_STATUS, "cleared", 8'h00);
        // interrupt raised and cleared by the vector
        bus(1'b1, `SMSC_OFS_CONTROL, 8'hd0);
        gie <= 1'b1;
        start(8'h42);
        wait_done();
        repeat (2) @(posedge clk);
        check("irq", 8'h01, 8'(irq));
        vecAck <= 1'b1;
        @(posedge clk);
        vecAck <= 1'b0;
        repeat (3) @(posedge clk);
        check("irq", 8'h00, 8'(irq));
        rdc(`SMSC_OFS_STATUS, "vector clear", 8'h00);
        // disabled: nothing moves
        bus(1'b1, `SMSC_OFS_CONTROL, 8'h10);
        start(8'h55);
        repeat (100) @(posedge clk);
        check("sck edges", 8'h00, edges[7:0]);
        rdc(`SMSC_OFS_STATUS, "status", 8'h00);
        // mode fault
        bus(1'b1, `SMSC_OFS_CONTROL, 8'h50);
        ssDir <= 1'b0;
        selN <= 1'b0;
        repeat (8) @(posedge clk);
        check("sck drive", 8'h01, 8'(sckOe_n));
        rdc(`SMSC_OFS_CONTROL, "role", 8'h40);
        rdc(`SMSC_OFS_STATUS, "fault done", 8'h80);
        bus(1'b0, `SMSC_OFS_DATA, 8'h00);
        selN <= 1'b1;
        bus(1'b1, `SMSC_OFS_CONTROL, 8'h50);
        rdc(`SMSC_OFS_CONTROL, "role", 8'h50);
        // slave: partial byte dropped, then a whole one
        bus(1'b1, `SMSC_OFS_CONTROL, 8'h40);
        slv(8'hff, 3);
        rdc(`SMSC_OFS_STATUS, "partial", 8'h00);
        bus(1'b1, `SMSC_OFS_DATA, 8'hc3);
        slv(8'h96, 8);
        check("miso drive", 8'h00, 8'(oeSeen));
        check("miso", 8'hc3, mGot);
        rdc(`SMSC_OFS_STATUS, "slave done", 8'h80);
        rdc(`SMSC_OFS_DATA, "slave rx", 8'h96);
        report_and_stop();
    end
endmodule : smsc_controller_test
